// file: core/bram_dual_port.sv
// True dual-port embedded block RAM with write modes and output latch resets
// Assumes fabric logic drives requests synchronous to clk
`timescale 1ns/1ps
`include "bram_params.svh"

module bram_dual_port #(
   parameter int unsigned          DATA_W      = `BRAM_DATA_W,
   parameter int unsigned          ADDR_W      = `BRAM_ADDR_W,
   parameter bram_pkg::bram_wmode_e MODE_A     = bram_pkg::BRAM_WR_NORMAL,
   parameter bram_pkg::bram_wmode_e MODE_B     = bram_pkg::BRAM_WR_NORMAL,
   parameter bit                   ASYNC_RST   = 1'b1,
   parameter bit                   OUT_REG_A   = 1'b0,
   parameter bit                   OUT_REG_B   = 1'b0
) (
   // Clock and resets
   input  wire logic               clk,
   input  wire logic               rstn,
   input  wire logic               global_set_reset_n,
   input  wire logic               port_a_latch_reset,
   input  wire logic               port_b_latch_reset,
   // Port requests
   input  wire bram_pkg::bram_req_s req_a,
   input  wire bram_pkg::bram_req_s req_b,
   // Read data
   output logic [DATA_W-1:0]       rdata_a,
   output logic [DATA_W-1:0]       rdata_b
);

   // Read-before-write only exists at x9, x18 and x36
   localparam bit WIDTH_OK = (DATA_W == `BRAM_WIDTH_X9) || (DATA_W == `BRAM_WIDTH_X18)
                             || (DATA_W == `BRAM_WIDTH_X36);
   localparam bram_pkg::bram_wmode_e EFF_A =
      (MODE_A == bram_pkg::BRAM_WR_READ_FIRST && !WIDTH_OK) ? bram_pkg::BRAM_WR_NORMAL : MODE_A;
   localparam bram_pkg::bram_wmode_e EFF_B =
      (MODE_B == bram_pkg::BRAM_WR_READ_FIRST && !WIDTH_OK) ? bram_pkg::BRAM_WR_NORMAL : MODE_B;

   logic [DATA_W-1:0]   mem [2**ADDR_W];
   bram_pkg::bram_req_s in_a_reg;
   bram_pkg::bram_req_s in_b_reg;
   logic [DATA_W-1:0]   latch_a_reg;
   logic [DATA_W-1:0]   latch_b_reg;
   logic [DATA_W-1:0]   latch_a_next;
   logic [DATA_W-1:0]   latch_b_next;
   logic                upd_a;
   logic                upd_b;
   logic                arst_a_n;
   logic                arst_b_n;
   logic                clr_a;
   logic                clr_b;

   // Input registers at the array
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         in_a_reg <= '0;
         in_b_reg <= '0;
      end
      else
      begin
         in_a_reg <= req_a;
         in_b_reg <= req_b;
      end
   end

   // Array write; port B wins on a same-address collision
   always_ff @(posedge clk)
   begin
      if (in_a_reg.ce && in_a_reg.we)
         mem[in_a_reg.addr] <= in_a_reg.wdata[DATA_W-1:0];
      if (in_b_reg.ce && in_b_reg.we)
         mem[in_b_reg.addr] <= in_b_reg.wdata[DATA_W-1:0];
   end

   // Output latch update by write mode
   always_comb
   begin
      upd_a        = 1'b0;
      latch_a_next = mem[in_a_reg.addr];
      if (in_a_reg.ce && !in_a_reg.we)
         upd_a = 1'b1;
      else if (in_a_reg.ce)
      begin
         case (EFF_A)
            bram_pkg::BRAM_WR_NORMAL:     upd_a = 1'b0;
            bram_pkg::BRAM_WR_THROUGH:
            begin
               upd_a        = 1'b1;
               latch_a_next = in_a_reg.wdata[DATA_W-1:0];
            end
            bram_pkg::BRAM_WR_READ_FIRST: upd_a = 1'b1;
            default:                      upd_a = 1'b0;
         endcase
      end
   end

   always_comb
   begin
      upd_b        = 1'b0;
      latch_b_next = mem[in_b_reg.addr];
      if (in_b_reg.ce && !in_b_reg.we)
         upd_b = 1'b1;
      else if (in_b_reg.ce)
      begin
         case (EFF_B)
            bram_pkg::BRAM_WR_NORMAL:     upd_b = 1'b0;
            bram_pkg::BRAM_WR_THROUGH:
            begin
               upd_b        = 1'b1;
               latch_b_next = in_b_reg.wdata[DATA_W-1:0];
            end
            bram_pkg::BRAM_WR_READ_FIRST: upd_b = 1'b1;
            default:                      upd_b = 1'b0;
         endcase
      end
   end

   // Reset style selects the asynchronous or synchronous clear path
   assign arst_a_n = rstn && (!ASYNC_RST || (global_set_reset_n && !port_a_latch_reset));
   assign arst_b_n = rstn && (!ASYNC_RST || (global_set_reset_n && !port_b_latch_reset));
   assign clr_a    = !ASYNC_RST && (!global_set_reset_n || port_a_latch_reset);
   assign clr_b    = !ASYNC_RST && (!global_set_reset_n || port_b_latch_reset);

   always_ff @(posedge clk or negedge arst_a_n)
   begin
      if (!arst_a_n)
         latch_a_reg <= '0;
      else if (clr_a)
         latch_a_reg <= '0;
      else if (upd_a)
         latch_a_reg <= latch_a_next;
   end

   always_ff @(posedge clk or negedge arst_b_n)
   begin
      if (!arst_b_n)
         latch_b_reg <= '0;
      else if (clr_b)
         latch_b_reg <= '0;
      else if (upd_b)
         latch_b_reg <= latch_b_next;
   end

   // Optional output register stage
   generate
      if (OUT_REG_A)
      begin : g_oreg_a
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
               rdata_a <= '0;
            else
               rdata_a <= latch_a_reg;
         end
      end
      else
      begin : g_noreg_a
         assign rdata_a = latch_a_reg;
      end
      if (OUT_REG_B)
      begin : g_oreg_b
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
               rdata_b <= '0;
            else
               rdata_b <= latch_b_reg;
         end
      end
      else
      begin : g_noreg_b
         assign rdata_b = latch_b_reg;
      end
   endgenerate

   // Checks
   a_normal_write_hold: assert property (@(posedge clk) disable iff (!rstn)
      (EFF_A == bram_pkg::BRAM_WR_NORMAL && in_a_reg.ce && in_a_reg.we && global_set_reset_n
       && !port_a_latch_reset) |=> (!global_set_reset_n || port_a_latch_reset
       || $stable(latch_a_reg)))
      else $error("normal write changed port A output");
   a_through_write_data: assert property (@(posedge clk) disable iff (!rstn)
      (EFF_B == bram_pkg::BRAM_WR_THROUGH && in_b_reg.ce && in_b_reg.we && global_set_reset_n
       && !port_b_latch_reset) |=> (!global_set_reset_n || port_b_latch_reset
       || latch_b_reg == $past(in_b_reg.wdata[DATA_W-1:0])))
      else $error("write-through data missing on port B");
   a_read_first_old: assert property (@(posedge clk) disable iff (!rstn)
      (EFF_A == bram_pkg::BRAM_WR_READ_FIRST && in_a_reg.ce && in_a_reg.we && global_set_reset_n
       && !port_a_latch_reset) |=> (!global_set_reset_n || port_a_latch_reset
       || latch_a_reg == $past(mem[in_a_reg.addr])))
      else $error("read-before-write old data wrong on port A");
   a_input_capture: assert property (@(posedge clk) disable iff (!rstn)
      1'b1 |=> in_a_reg == $past(req_a) && in_b_reg == $past(req_b))
      else $error("input registers did not capture request");
   a_local_clear_a: assert property (@(posedge clk) disable iff (!rstn)
      port_a_latch_reset |=> latch_a_reg == '0)
      else $error("port A latch not cleared");
   a_local_clear_b: assert property (@(posedge clk) disable iff (!rstn)
      port_b_latch_reset |=> latch_b_reg == '0)
      else $error("port B latch not cleared");
   a_global_clear: assert property (@(posedge clk) disable iff (!rstn)
      !global_set_reset_n |=> latch_a_reg == '0 && latch_b_reg == '0)
      else $error("global reset did not clear both latches");
   a_cleared_stays: assert property (@(posedge clk) disable iff (!rstn)
      (latch_a_reg == '0 && !upd_a) |=> latch_a_reg == '0)
      else $error("cleared port A latch changed without a read");
   a_out_latency: assert property (@(posedge clk) disable iff (!rstn)
      1'b1 |=> rdata_b == (OUT_REG_B ? $past(latch_b_reg) : latch_b_reg))
      else $error("output register latency wrong on port B");

   c_read_a:  cover property (@(posedge clk) in_a_reg.ce && !in_a_reg.we);
   c_write_b: cover property (@(posedge clk) in_b_reg.ce && in_b_reg.we);
   c_local_a: cover property (@(posedge clk) port_a_latch_reset && !port_b_latch_reset);
   c_global:  cover property (@(posedge clk) !global_set_reset_n);

endmodule // bram_dual_port

// file: core/bram_params.svh
// Constants for the dual-port block RAM with write modes and latch resets
// Assumes inclusion by core/bram_pkg.sv and core/bram_dual_port.sv
`ifndef BRAM_PARAMS_SVH
`define BRAM_PARAMS_SVH
`define BRAM_DATA_W      36
`define BRAM_ADDR_W      9
`define BRAM_DOUT_RESET  36'h0
`define BRAM_WIDTH_X9    6'h09
`define BRAM_WIDTH_X18   6'h12
`define BRAM_WIDTH_X36   6'h24
`endif

// file: core/bram_pkg.sv
// Types for the dual-port block RAM
// Assumes bram_params.svh for widths
`include "bram_params.svh"
package bram_pkg;
   typedef enum logic [1:0] {
      BRAM_WR_NORMAL,
      BRAM_WR_THROUGH,
      BRAM_WR_READ_FIRST
   } bram_wmode_e;

   typedef struct packed {
      logic                     ce;
      logic                     we;
      logic [`BRAM_ADDR_W-1:0]  addr;
      logic [`BRAM_DATA_W-1:0]  wdata;
   } bram_req_s;
endpackage

// file: test/bram_fabric.sv
// Fabric-side user logic model that drives both ports of the block RAM
// Assumes the bench calls issue shortly after each rising clock edge
`timescale 1ns/1ps
module bram_fabric (
   // Port requests
   output bram_pkg::bram_req_s req_a,
   output bram_pkg::bram_req_s req_b,
   // Latch resets
   output logic                port_a_latch_reset,
   output logic                port_b_latch_reset,
   output logic                global_set_reset_n
);
   initial
   begin
      issue('0, '0, 3'h0);
   end

   // Idle cycles still carry random address and data with ce low
   task automatic issue(input bram_pkg::bram_req_s ra, input bram_pkg::bram_req_s rb,
                        input logic [2:0] rst);
      req_a = ra;
      req_b = rb;
      port_a_latch_reset = rst[0];
      port_b_latch_reset = rst[1];
      global_set_reset_n = ~rst[2];
   endtask
endmodule // bram_fabric

// file: test/tb_block_ram_write_modes_reset.sv
// Self-checking bench for two block RAM instances with all write modes
// Assumes the design package and bram_params.svh are compiled first
`timescale 1ns/1ps
`include "bram_params.svh"
module tb_block_ram_write_modes_reset;
   localparam int NOPS = 400;
   logic                  clk = 1'b0;
   logic                  rstn = 1'b0;
   logic                  rst_a, rst_b, gsr_n;
   bram_pkg::bram_req_s   req_a, req_b, ra, rb;
   logic [35:0]           r1a, r1b, r2a, r2b, old_a, old_b;
   logic [35:0]           mem [0:31];
   logic [35:0]           lat [0:3];
   logic [35:0]           hist [0:NOPS-1][0:3];
   logic [31:0]           v, w;
   logic [2:0]            rs;
   int                    seed = 80608;
   int                    fail_count = 0;
   int                    samples_checked = 0;
   int                    cyc = 0;
   int                    ph;

   always #12.5 clk = ~clk;

   bram_fabric bram_fabric_inst (.req_a(req_a), .req_b(req_b), .port_a_latch_reset(rst_a),
      .port_b_latch_reset(rst_b), .global_set_reset_n(gsr_n));
   bram_dual_port #(.MODE_A(bram_pkg::BRAM_WR_NORMAL), .MODE_B(bram_pkg::BRAM_WR_THROUGH),
      .ASYNC_RST(1'b1), .OUT_REG_B(1'b1)) bram_dual_port_inst (.clk(clk), .rstn(rstn),
      .global_set_reset_n(gsr_n), .port_a_latch_reset(rst_a), .port_b_latch_reset(rst_b),
      .req_a(req_a), .req_b(req_b), .rdata_a(r1a), .rdata_b(r1b));
   bram_dual_port #(.MODE_A(bram_pkg::BRAM_WR_READ_FIRST), .MODE_B(bram_pkg::BRAM_WR_NORMAL),
      .ASYNC_RST(1'b0)) bram_dual_port_inst2 (.clk(clk), .rstn(rstn),
      .global_set_reset_n(gsr_n), .port_a_latch_reset(rst_a), .port_b_latch_reset(rst_b),
      .req_a(req_a), .req_b(req_b), .rdata_a(r2a), .rdata_b(r2b));

   // Expected output latch after one access
   function automatic logic [35:0] upd(input bram_pkg::bram_wmode_e m, input logic [35:0] cur,
                                     input bram_pkg::bram_req_s r, input logic [35:0] old);
      if (!r.ce)
         return cur;
      if (!r.we || m == bram_pkg::BRAM_WR_READ_FIRST)
         return old;
      return (m == bram_pkg::BRAM_WR_THROUGH) ? r.wdata : cur;
   endfunction

   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == NOPS + 100)
      begin
         fail_count++;
         results();
      end
   end

   initial
   begin
      for (int p = 0; p < 4; p++)
         lat[p] = '0;
      repeat (20) @(posedge clk);
      #1 rstn = 1'b1;
      for (int i = 0; i < NOPS; i++)
      begin
         @(posedge clk);
         #1;
         ph = i % 50;
         if (i >= 20 && ph != 45 && ph != 46)
         begin
            check(r1a, hist[i-2][0]);
            check(r1b, hist[i-3][1]);
            check(r2a, hist[i-2][2]);
            check(r2b, hist[i-2][3]);
         end
         v = $random(seed);
         w = $random(seed);
         // Two fill passes write addresses 0 to 31, then random traffic with reset windows
         ra = {i < 32 || (ph < 40 && v[0]), i < 32 || v[1], 5'h00,
               (i < 32) ? 4'(i) : v[5:2], w[3:0], w};
         rb = {i < 32 || (ph < 40 && v[6]), i < 32 || v[7], 5'h01,
               (i < 32) ? 4'(i) : v[11:8], v[3:0], w ^ v};
         rs = (ph == 44) ? (3'h1 << ((i / 50) % 3)) : 3'h0;
         bram_fabric_inst.issue(ra, rb, rs);
         if (rs[0] || rs[2])
            {lat[0], lat[2]} = '0;
         if (rs[1] || rs[2])
            {lat[1], lat[3]} = '0;
         old_a = mem[ra.addr[4:0]];
         old_b = mem[rb.addr[4:0]];
         lat[0] = upd(bram_pkg::BRAM_WR_NORMAL, lat[0], ra, old_a);
         lat[1] = upd(bram_pkg::BRAM_WR_THROUGH, lat[1], rb, old_b);
         lat[2] = upd(bram_pkg::BRAM_WR_READ_FIRST, lat[2], ra, old_a);
         lat[3] = upd(bram_pkg::BRAM_WR_NORMAL, lat[3], rb, old_b);
         if (ra.ce && ra.we)
            mem[ra.addr[4:0]] = ra.wdata;
         if (rb.ce && rb.we)
            mem[rb.addr[4:0]] = rb.wdata;
         hist[i] = lat;
      end
      results();
   end
endmodule // tb_block_ram_write_modes_reset
